//--- hdl/mpot_pkg.sv
package mpot_pkg;

  // Register byte offsets
  localparam logic [11:0] MPOT_CTRL_OFF = 12'h000;
  localparam logic [11:0] MPOT_MAX_OFF = 12'h004;
  localparam logic [11:0] MPOT_MIN_OFF = 12'h008;
  localparam logic [11:0] MPOT_START_OFF = 12'h00C;
  localparam logic [11:0] MPOT_STEP_OFF = 12'h010;
  localparam logic [11:0] MPOT_RUP_OFF = 12'h014;
  localparam logic [11:0] MPOT_RDN_OFF = 12'h018;
  localparam logic [11:0] MPOT_VALUE_OFF = 12'h01C;
  localparam logic [11:0] MPOT_SAVED_OFF = 12'h020;
  localparam logic [11:0] MPOT_STATUS_OFF = 12'h024;

  // Control field positions
  localparam int MPOT_FUNC_LSB = 0;
  localparam int MPOT_RMODE_BIT = 2;
  localparam int MPOT_SMODE_LSB = 3;
  localparam int MPOT_STOP_BIT = 8;
  localparam int MPOT_MOFF_BIT = 9;

  // Function, reset and save modes
  localparam logic [1:0] MPOT_FUNC_OFF = 2'h0;
  localparam logic [1:0] MPOT_FUNC_TIME = 2'h1;
  localparam logic [1:0] MPOT_FUNC_EDGE = 2'h2;
  localparam logic MPOT_RST_AT_START = 1'b0;
  localparam logic MPOT_RST_BOTH = 1'b1;
  localparam logic [1:0] MPOT_SAVE_NONE = 2'h0;
  localparam logic [1:0] MPOT_SAVE_MAINS = 2'h1;
  localparam logic [1:0] MPOT_SAVE_STOP = 2'h2;

  // Reset values
  localparam logic [31:0] MPOT_CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] MPOT_MAX_RST = 32'h0000_0528;
  localparam logic [31:0] MPOT_MIN_RST = 32'h0000_0000;
  localparam logic [31:0] MPOT_START_RST = 32'h0000_0000;
  localparam logic [31:0] MPOT_STEP_RST = 32'h0000_000A;

  // Timing
  localparam int MPOT_CLK_HZ = 40_000_000;
  localparam int MPOT_RAMP_MS = 10000;
  localparam int MPOT_CYC_PER_MS = MPOT_CLK_HZ / 1000;
  localparam int MPOT_DEB_US = 5;
  localparam int MPOT_DEB_CYC = (MPOT_DEB_US * MPOT_CLK_HZ) / 1_000_000;

endpackage : mpot_pkg

//--- hdl/mpot_setpoint.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - With the function disabled the value stays put and both inputs are ignored.
// - The increment input raises the value and the decrement input lowers it.
// - In time mode the value keeps moving while the matching input is held high.
// - In edge mode only a rising edge changes the value, a held level does nothing more.
// - In edge mode each rising edge adds or subtracts the step size.
// - In start reset mode the start value is loaded at every power-up.
// - In both-input reset mode the start value is loaded while both inputs are active.
// - With save mode none the value is never written to the saved store.
// - With save mode mains-off the value is saved when mains-off is signalled.
// - With save mode stop the value is saved when a stop command is issued.
// - Increments never carry the value above the maximum.
// - Decrements never carry the value below the minimum.
// - Every reset event loads the start value, zero by default, and work goes on from it.
// - In time mode the up rate runs from zero to maximum in the ramp-up time.
// - In time mode the down rate runs from maximum to zero in the ramp-down time.
module mpot_setpoint
  import mpot_pkg::*;
#(
  parameter int RAMP_UP_MS = MPOT_RAMP_MS,
  parameter int RAMP_DN_MS = MPOT_RAMP_MS,
  parameter int CYC_PER_MS = MPOT_CYC_PER_MS,
  parameter int DEB_CYC = MPOT_DEB_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic increment_input,
  input wire logic decrement_input,
  input wire logic mains_off,
  input wire logic stop_cmd,
  output logic [31:0] motor_pot_value,
  output logic [31:0] motor_pot_saved,
  output logic save_pulse
);

  // Configuration registers
  logic [31:0] ctrl_reg;
  logic [31:0] max_reg;
  logic [31:0] min_reg;
  logic [31:0] start_reg;
  logic [31:0] step_reg;
  logic [31:0] rup_reg;
  logic [31:0] rdn_reg;
  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic [31:0] saved_reg;
  logic [31:0] prdata_reg;
  logic save_reg;
  logic pslverr_reg;
  logic boot_reg;

  wire logic [1:0] func = ctrl_reg[MPOT_FUNC_LSB +: 2];
  wire logic rmode = ctrl_reg[MPOT_RMODE_BIT];
  wire logic [1:0] smode = ctrl_reg[MPOT_SMODE_LSB +: 2];

  // Input synchronisers, two stages each, plus a stable-count filter
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic [1:0] db_reg;
  logic [1:0] db_prev_reg;
  logic [1:0] s3_reg;
  logic [15:0] deb_cnt_reg [2];
  wire logic [15:0] deb_lim = 16'(DEB_CYC);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_deb
      // Filter restarts whenever the synchronised level moves
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          deb_cnt_reg[gi] <= 16'h0000;
          db_reg[gi] <= 1'b0;
        end
        else if (s2_reg[gi] != s3_reg[gi])
          deb_cnt_reg[gi] <= 16'h0000;
        else if (deb_cnt_reg[gi] >= deb_lim)
          db_reg[gi] <= s3_reg[gi];
        else
          deb_cnt_reg[gi] <= deb_cnt_reg[gi] + 16'h0001;
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
      s3_reg <= 2'h0;
      db_prev_reg <= 2'h0;
    end
    else
    begin
      s1_reg <= {decrement_input, increment_input};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      db_prev_reg <= db_reg;
    end
  end

  // Command qualification
  wire logic up_lvl = db_reg[0];
  wire logic dn_lvl = db_reg[1];
  wire logic both = up_lvl & dn_lvl;
  wire logic up_edge = db_reg[0] & ~db_prev_reg[0];
  wire logic dn_edge = db_reg[1] & ~db_prev_reg[1];
  wire logic enabled = (func == MPOT_FUNC_TIME) || (func == MPOT_FUNC_EDGE);
  wire logic both_reset = enabled && both && (rmode == MPOT_RST_BOTH);

  // Rate generator: one LSB per tick, tick period = ramp_time * cycles_per_ms / max
  logic [47:0] acc_reg;
  wire logic [47:0] up_span = 48'(rup_reg) * 48'(CYC_PER_MS);
  wire logic [47:0] dn_span = 48'(rdn_reg) * 48'(CYC_PER_MS);
  wire logic go_up_t = (func == MPOT_FUNC_TIME) && up_lvl && !both;
  wire logic go_dn_t = (func == MPOT_FUNC_TIME) && dn_lvl && !both;
  wire logic [47:0] acc_sum = acc_reg + 48'(max_reg);
  wire logic [47:0] span = go_up_t ? up_span : dn_span;
  wire logic tick = (go_up_t || go_dn_t) && (acc_sum >= span);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_reg <= 48'h0;
    else if (!(go_up_t || go_dn_t))
      acc_reg <= 48'h0;
    else if (tick)
      acc_reg <= acc_sum - span;
    else
      acc_reg <= acc_sum;
  end

  // Saturating add and subtract against the limits
  wire logic [32:0] inc_amt = (func == MPOT_FUNC_EDGE) ? {1'b0, step_reg} : 33'h1;
  wire logic [32:0] up_sum = {1'b0, value_reg} + inc_amt;
  wire logic [32:0] dn_room = {1'b0, value_reg} - {1'b0, min_reg};
  wire logic [31:0] up_val = (up_sum > {1'b0, max_reg}) ? max_reg : up_sum[31:0];
  wire logic [31:0] dn_val = (dn_room[32] || dn_room < inc_amt) ? min_reg
                             : value_reg - inc_amt[31:0];
  wire logic do_up = (func == MPOT_FUNC_EDGE) ? (up_edge && !dn_lvl) : (go_up_t && tick);
  wire logic do_dn = (func == MPOT_FUNC_EDGE) ? (dn_edge && !up_lvl) : (go_dn_t && tick);

  // Next motor pot value, reset loads win over movement
  always_comb
  begin
    value_next = value_reg;
    if (boot_reg)
      value_next = start_reg;
    else if (!enabled)
      value_next = value_reg;
    else if (both_reset)
      value_next = start_reg;
    else if (both)
      value_next = value_reg;
    else if (do_up)
      value_next = up_val;
    else if (do_dn)
      value_next = dn_val;
  end

  // Save triggers: live input is synchronised, software bit is not
  logic [1:0] ev1_reg;
  logic [1:0] ev2_reg;
  logic [1:0] ev3_reg;
  wire logic moff_rise = ev2_reg[0] & ~ev3_reg[0];
  wire logic stop_rise = ev2_reg[1] & ~ev3_reg[1];
  wire logic bus_wr = psel && penable && pwrite;
  wire logic ctrl_wr = bus_wr && (paddr == MPOT_CTRL_OFF);
  wire logic sw_stop = ctrl_wr && pwdata[MPOT_STOP_BIT];
  wire logic sw_moff = ctrl_wr && pwdata[MPOT_MOFF_BIT];
  wire logic do_save = ((smode == MPOT_SAVE_MAINS) && (moff_rise || sw_moff))
                    || ((smode == MPOT_SAVE_STOP) && (stop_rise || sw_stop));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ev1_reg <= 2'h0;
      ev2_reg <= 2'h0;
      ev3_reg <= 2'h0;
    end
    else
    begin
      ev1_reg <= {stop_cmd, mains_off};
      ev2_reg <= ev1_reg;
      ev3_reg <= ev2_reg;
    end
  end

  // Value, saved copy and power-up marker; presetn clears the saved store as well
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value_reg <= MPOT_START_RST;
      saved_reg <= MPOT_START_RST;
      save_reg <= 1'b0;
      boot_reg <= 1'b1;
    end
    else
    begin
      value_reg <= value_next;
      boot_reg <= 1'b0;
      save_reg <= do_save;
      if (do_save)
        saved_reg <= value_reg;
    end
  end

  // APB decode; zero wait states, unmapped addresses answer with an error
  wire logic hit_ro = (paddr == MPOT_VALUE_OFF) || (paddr == MPOT_SAVED_OFF)
                   || (paddr == MPOT_STATUS_OFF);
  wire logic hit_rw = (paddr == MPOT_CTRL_OFF) || (paddr == MPOT_MAX_OFF)
                   || (paddr == MPOT_MIN_OFF) || (paddr == MPOT_START_OFF)
                   || (paddr == MPOT_STEP_OFF) || (paddr == MPOT_RUP_OFF)
                   || (paddr == MPOT_RDN_OFF);
  wire logic [31:0] status = {28'h0, db_reg, enabled, both};
  wire logic [31:0] rd_mux =
      (paddr == MPOT_CTRL_OFF) ? {27'h0, ctrl_reg[4:0]} :
      (paddr == MPOT_MAX_OFF) ? max_reg :
      (paddr == MPOT_MIN_OFF) ? min_reg :
      (paddr == MPOT_START_OFF) ? start_reg :
      (paddr == MPOT_STEP_OFF) ? step_reg :
      (paddr == MPOT_RUP_OFF) ? rup_reg :
      (paddr == MPOT_RDN_OFF) ? rdn_reg :
      (paddr == MPOT_VALUE_OFF) ? value_reg :
      (paddr == MPOT_SAVED_OFF) ? saved_reg :
      (paddr == MPOT_STATUS_OFF) ? status : 32'h0000_0000;

  // Setup phase registers the answer so it is ready in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end
    else if (psel && !penable)
    begin
      prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_reg <= !(hit_rw || (hit_ro && !pwrite));
    end
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= MPOT_CTRL_RST;
      max_reg <= MPOT_MAX_RST;
      min_reg <= MPOT_MIN_RST;
      start_reg <= MPOT_START_RST;
      step_reg <= MPOT_STEP_RST;
      rup_reg <= 32'(RAMP_UP_MS);
      rdn_reg <= 32'(RAMP_DN_MS);
    end
    else if (bus_wr)
    begin
      if (paddr == MPOT_CTRL_OFF)
        ctrl_reg <= {27'h0, pwdata[4:0]};
      if (paddr == MPOT_MAX_OFF)
        max_reg <= pwdata;
      if (paddr == MPOT_MIN_OFF)
        min_reg <= pwdata;
      if (paddr == MPOT_START_OFF)
        start_reg <= pwdata;
      if (paddr == MPOT_STEP_OFF)
        step_reg <= pwdata;
      if (paddr == MPOT_RUP_OFF)
        rup_reg <= pwdata;
      if (paddr == MPOT_RDN_OFF)
        rdn_reg <= pwdata;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = pslverr_reg;
  assign motor_pot_value = value_reg;
  assign motor_pot_saved = saved_reg;
  assign save_pulse = save_reg;

endmodule : mpot_setpoint

`default_nettype wire

//--- tb/mpot_setpoint_props.sv
`timescale 1ns/1ps
`default_nettype none
// Checks the pins; shadows of three registers follow APB writes
module mpot_setpoint_props
  import mpot_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] motor_pot_value,
  input wire logic [31:0] motor_pot_saved,
  input wire logic save_pulse
);
  logic [31:0] ctrl_reg;
  logic [31:0] max_reg;
  logic [31:0] step_reg;
  wire logic wr_acc;
  assign wr_acc = psel && penable && pwrite && pready;
  // Shadows change at the edge where the write lands, as the block's own
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_reg <= MPOT_CTRL_RST;
      max_reg <= MPOT_MAX_RST;
      step_reg <= MPOT_STEP_RST;
    end
    else
    begin
      ctrl_reg <= (wr_acc && paddr == MPOT_CTRL_OFF) ? pwdata : ctrl_reg;
      max_reg <= (wr_acc && paddr == MPOT_MAX_OFF) ? pwdata : max_reg;
      step_reg <= (wr_acc && paddr == MPOT_STEP_OFF) ? pwdata : step_reg;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rise;
    motor_pot_value > $past(motor_pot_value);
  endsequence
  sequence s_time_rise;
    ctrl_reg[1:0] == MPOT_FUNC_TIME ##0 s_rise;
  endsequence
  property p_max;
    s_rise |-> motor_pot_value <= max_reg;
  endproperty
  property p_off;
    ctrl_reg[1:0] == MPOT_FUNC_OFF |-> $stable(motor_pot_value);
  endproperty
  property p_time;
    s_time_rise |-> motor_pot_value == $past(motor_pot_value) + 32'h1;
  endproperty
  property p_step;
    (ctrl_reg[1:0] == MPOT_FUNC_EDGE) ##0 s_rise
      |-> motor_pot_value - $past(motor_pot_value) <= step_reg;
  endproperty
  property p_none;
    ctrl_reg[4:3] == MPOT_SAVE_NONE |-> !save_pulse;
  endproperty
  property p_cap;
    save_pulse |-> motor_pot_saved == $past(motor_pot_value);
  endproperty
  property p_hold;
    !save_pulse |-> $stable(motor_pot_saved);
  endproperty
  property p_one;
    save_pulse |=> !save_pulse;
  endproperty
  a_max: assert property (p_max) else $error("value rose above max");
  a_off: assert property (p_off) else $error("value moved while off");
  a_time: assert property (p_time) else $error("ramp step not one");
  a_step: assert property (p_step) else $error("edge step too big");
  a_none: assert property (p_none) else $error("save in no-save mode");
  a_cap: assert property (p_cap) else $error("saved copy wrong");
  a_hold: assert property (p_hold) else $error("saved moved unasked");
  a_one: assert property (p_one) else $error("save pulse too long");
endmodule : mpot_setpoint_props

bind mpot_setpoint mpot_setpoint_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .motor_pot_value(motor_pot_value),
  .motor_pot_saved(motor_pot_saved), .save_pulse(save_pulse));
`default_nettype wire

//--- tb/mpot_switch.sv
`timescale 1ns/1ps
`default_nettype none
module mpot_switch
(
  input wire logic pclk,
  input wire logic press,
  output logic pin
);
  logic [2:0] hist_reg = 3'h0;
  // A real contact chatters: new level, one cycle back at the old, then settled
  always @(posedge pclk)
    hist_reg <= {hist_reg[1:0], press};
  assign pin = (hist_reg[0] != hist_reg[1]) ? hist_reg[0] :
               (hist_reg[1] != hist_reg[2]) ? hist_reg[2] : hist_reg[0];
endmodule : mpot_switch
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mpot_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic up_cmd = 1'b0;
  logic dn_cmd = 1'b0;
  logic mains_off = 1'b0;
  logic stop_cmd = 1'b0;
  wire logic [31:0] prdata, value, saved;
  wire logic pready, pslverr, save_pulse, inc_pin, dec_pin;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] q;
  logic e;
  always #12.5 pclk = ~pclk;
  // Short ms and debounce so a full ramp takes tens of cycles
  mpot_setpoint #(.RAMP_UP_MS(10), .RAMP_DN_MS(10), .CYC_PER_MS(4), .DEB_CYC(2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .increment_input(inc_pin), .decrement_input(dec_pin), .mains_off(mains_off),
    .stop_cmd(stop_cmd), .motor_pot_value(value), .motor_pot_saved(saved),
    .save_pulse(save_pulse));
  mpot_switch sw_up (.pclk(pclk), .press(up_cmd), .pin(inc_pin));
  mpot_switch sw_dn (.pclk(pclk), .press(dn_cmd), .pin(dec_pin));
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task hold(input logic u, input logic d, input int n);
    @(posedge pclk);
    up_cmd <= u;
    dn_cmd <= d;
    repeat (n) @(posedge pclk);
  endtask : hold
  task tap(input logic u, input logic d, input logic [31:0] exp);
    hold(u, d, 16);
    chk("value", exp, value);
    hold(1'b0, 1'b0, 16);
  endtask : tap
  // Pulses a save trigger and counts save pulses; each edge reads the cycle just ended
  task trig(input logic m, input logic s, input int n_exp);
    int n;
    n = 0;
    @(posedge pclk);
    mains_off <= m;
    stop_cmd <= s;
    repeat (4)
    begin
      @(posedge pclk);
      n += int'(save_pulse);
    end
    mains_off <= 1'b0;
    stop_cmd <= 1'b0;
    repeat (6)
    begin
      @(posedge pclk);
      n += int'(save_pulse);
    end
    chk("save pulses", 32'(n_exp), 32'(n));
  endtask : trig
  function logic [31:0] cfg(input logic [1:0] f, input logic rm, input logic [1:0] sm);
    return {27'h0, sm, rm, f};
  endfunction : cfg
  task t_regs;
    apb(1'b0, MPOT_CTRL_OFF, 32'h0);
    chk("ctrl", MPOT_CTRL_RST, q);
    apb(1'b0, MPOT_MAX_OFF, 32'h0);
    chk("max", MPOT_MAX_RST, q);
    apb(1'b0, MPOT_START_OFF, 32'h0);
    chk("start", MPOT_START_RST, q);
    chk("value", 32'h0, value);
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    apb(1'b1, MPOT_VALUE_OFF, 32'h5);
    chk("ro write", 32'h1, {31'h0, e});
  endtask : t_regs
  task t_time;
    apb(1'b1, MPOT_MAX_OFF, 32'h8);
    hold(1'b1, 1'b0, 30);
    chk("ramp mid", 32'h1, {31'h0, value < 32'h8 && value != 32'h0});
    hold(1'b1, 1'b0, 50);
    chk("ramp top", 32'h8, value);
    hold(1'b0, 1'b1, 80);
    chk("ramp low", 32'h0, value);
    hold(1'b0, 1'b0, 16);
  endtask : t_time
  task t_edge;
    apb(1'b1, MPOT_MAX_OFF, 32'h28);
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_EDGE, MPOT_RST_AT_START, MPOT_SAVE_NONE));
    for (int i = 1; i <= 5; i++)
      tap(1'b1, 1'b0, (i < 5) ? 32'(10 * i) : 32'h28);
    hold(1'b0, 1'b1, 60);
    chk("held", 32'h1E, value);
    hold(1'b0, 1'b0, 16);
    for (int i = 1; i <= 4; i++)
      tap(1'b0, 1'b1, (i < 4) ? 32'(30 - 10 * i) : 32'h0);
  endtask : t_edge
  task t_both;
    apb(1'b1, MPOT_START_OFF, 32'h14);
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_EDGE, MPOT_RST_BOTH, MPOT_SAVE_NONE));
    tap(1'b1, 1'b0, 32'hA);
    tap(1'b1, 1'b1, 32'h14);
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_EDGE, MPOT_RST_AT_START, MPOT_SAVE_NONE));
    tap(1'b1, 1'b1, 32'h14);
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_OFF, MPOT_RST_AT_START, MPOT_SAVE_NONE));
    tap(1'b1, 1'b0, 32'h14);
  endtask : t_both
  task t_save;
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_EDGE, MPOT_RST_AT_START, MPOT_SAVE_MAINS));
    trig(1'b1, 1'b0, 1);
    chk("saved", 32'h14, saved);
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_EDGE, MPOT_RST_AT_START, MPOT_SAVE_NONE));
    tap(1'b1, 1'b0, 32'h1E);
    trig(1'b1, 1'b1, 0);
    chk("saved", 32'h14, saved);
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_EDGE, MPOT_RST_AT_START, MPOT_SAVE_STOP));
    trig(1'b0, 1'b1, 1);
    chk("saved", 32'h1E, saved);
    // Software stop bit takes the save without any pin activity
    tap(1'b1, 1'b0, 32'h28);
    apb(1'b1, MPOT_CTRL_OFF, cfg(MPOT_FUNC_EDGE, MPOT_RST_AT_START, MPOT_SAVE_STOP) | 32'h100);
    trig(1'b0, 1'b0, 0);
    chk("sw saved", 32'h28, saved);
  endtask : t_save
  // Main sequence, then a second power-up that must reload the start value
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_time;
    t_edge;
    t_both;
    t_save;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("value", MPOT_START_RST, value);
    final_report;
  end
  // Hang guard, well above the roughly nine hundred cycles the run needs
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      n_mismatch++;
      final_report;
    end
  end
endmodule : tb
`default_nettype wire
